/* File: common/pattern_test_pkg.sv */
// Package: register map, field positions, reset values and carriers for the pattern test block
package pattern_test_pkg;

    // ==============================================================
    // Register map (printed offsets are not multiples of four: index, byte = 4*index)
    localparam logic [15:0] CSR_INDEX      = 16'h0123;
    localparam logic [15:0] SWITCH_INDEX   = 16'h0121;
    localparam logic [17:0] CSR_ADDR       = {CSR_INDEX, 2'b00};
    localparam logic [17:0] SWITCH_ADDR    = {SWITCH_INDEX, 2'b00};

    // ==============================================================
    // Field positions
    localparam int BIT_TYPE      = 7;
    localparam int BIT_ERRINS    = 6;
    localparam int BIT_INVERT    = 5;
    localparam int BIT_LOCK      = 4;
    localparam int BIT_CHECK_EN  = 3;
    localparam int BIT_GEN_EN    = 2;
    localparam int BIT_RX_SKIP   = 1;
    localparam int BIT_TX_SKIP   = 0;
    localparam int BIT_SWITCH    = 3;

    // ==============================================================
    // Reset values and counts
    localparam logic [7:0]  CSR_RESET      = 8'h00;
    localparam logic [7:0]  SWITCH_RESET   = 8'h00;
    localparam logic [14:0] LFSR_SEED      = 15'h7FFF;
    localparam logic [4:0]  SEED_BITS      = 5'h0F;
    localparam logic [5:0]  LOCK_RUN       = 6'h20;
    localparam logic [3:0]  LOSS_ERRS      = 4'h8;
    localparam logic [4:0]  QRTS_ZERO_MAX  = 5'h0E;

    // ==============================================================
    // Carriers
    typedef struct packed {
        logic       patternTypeSelect;
        logic       singleErrorInject;
        logic       testDataInvert;
        logic       patternCheckEnable;
        logic       patternGenEnable;
        logic       rxFramerSkip;
        logic       txFramerSkip;
        logic       patternSwitch;
    } ctrl_s;

    typedef struct packed {
        logic       lineRxBit;
        logic       backTxBit;
        logic       framerTxBit;
        logic       framerRxBit;
    } stream_in_s;

    typedef struct packed {
        logic       lineTxBit;
        logic       backRxBit;
    } stream_out_s;

endpackage : pattern_test_pkg

/* File: design/pattern_checker.sv */
// Pattern checker: self-synchronising PRBS15 / QRTS detector with lock flag
`timescale 1ns/10ps
module pattern_checker (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic bitValid,
    input  wire logic qrts,
    input  wire logic dataIn,
    output logic      locked
);

    typedef struct packed {
        logic [14:0] shift;
        logic [4:0]  seeded;
        logic [5:0]  run;
        logic [3:0]  errs;
        logic        lock;
    } chk_s;

    chk_s st_r;
    chk_s st_nxt;
    logic expected;
    logic rawBit;

    // ==============================================================
    // Next state: seed from incoming bits, then count matches
    always_comb begin
        st_nxt   = st_r;
        expected = st_r.shift[14] ^ st_r.shift[13];
        // QRTS forces a one after too many zeros; compare to the raw LFSR bit
        rawBit   = expected;
        if (!enable) begin
            st_nxt = '0;
        end else if (bitValid) begin
            st_nxt.shift = {st_r.shift[13:0], dataIn};
            if (st_r.seeded != pattern_test_pkg::SEED_BITS) begin
                st_nxt.seeded = st_r.seeded + 5'h01;
            end else if (dataIn == rawBit || (qrts && dataIn)) begin
                if (st_r.run != pattern_test_pkg::LOCK_RUN) begin
                    st_nxt.run = st_r.run + 6'h01;
                end
                if (st_r.run == pattern_test_pkg::LOCK_RUN - 6'h01) begin
                    st_nxt.lock = 1'b1;
                    st_nxt.errs = '0;
                end
            end else begin
                st_nxt.run  = '0;
                st_nxt.errs = st_r.errs + 4'h1;
                // Too many errors while locked, or any error before lock: reseed and hunt again
                if (st_r.errs == pattern_test_pkg::LOSS_ERRS - 4'h1 || !st_r.lock) begin
                    st_nxt = '0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign locked = st_r.lock;

    a_lock_clears_off: assert property (@(posedge clk) disable iff (rst)
        !enable |=> !locked) else $error("lock held while checker disabled"); // RULE15

endmodule : pattern_checker

/* File: design/pattern_test_control.sv */
// Top: pattern generator, checker routing, framer bypass and Wishbone register slave
// How it works
// RULE1 - Switch bit in its own register routes generation and checking line or backplane side.
// RULE2 - Bit 4 reads 1 when the active checker has locked, else 0.
// RULE3 - Lock flag shows receive or transmit checker as chosen by the switch.
// RULE4 - Bit 3 enables pattern checking; 0 disables it.
// RULE5 - Switch off: check line receive data and lock onto the pattern.
// RULE6 - Switch on: check transmit backplane data and lock onto the pattern.
// RULE7 - Bit 2 enables the pattern generator; 0 disables it.
// RULE8 - Switch off: generated pattern replaces transmit data toward the line.
// RULE9 - Switch on: generated pattern goes out on the receive backplane side.
// RULE10 - Bit 1 bypasses receive framing; 0 keeps normal receive framing.
// RULE11 - Bit 0 bypasses transmit framing; 0 keeps normal transmit framing.
// RULE12 - Type bit 0 picks PRBS15 x^15+x^14+1, 1 picks quasi-random signal.
// RULE13 - Each rising edge of error insert flips one generated bit, only while generating.
// RULE14 - Invert bit inverts generated output and checked input on switched paths.
// RULE15 - Lock after 15 seed bits and a matching run; cleared when checking disabled.
// RULE16 - After reset lock, enables and bypass bits all read zero.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
module pattern_test_control (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        wbCyc,
    input  wire logic                        wbStb,
    input  wire logic                        wbWe,
    input  wire logic [17:0]                 wbAdr,
    input  wire logic [3:0]                  wbSel,
    input  wire logic [31:0]                 wbDatI,
    output logic      [31:0]                 wbDatO,
    output logic                             wbAck,
    input  wire logic                        bitValid,
    input  wire pattern_test_pkg::stream_in_s streamIn,
    output pattern_test_pkg::stream_out_s    streamOut,
    output logic                             rxFramerSkip,
    output logic                             txFramerSkip
);

    // ==============================================================
    // State
    typedef struct packed {
        pattern_test_pkg::ctrl_s       ctrl;
        logic [14:0]                   lfsr;
        logic [4:0]                    zeros;
        logic                          injectPend;
        logic [31:0]                   datO;
        logic                          ack;
        pattern_test_pkg::stream_out_s out;
        logic                          rxSkip;
        logic                          txSkip;
    } top_s;

    top_s st_r;
    top_s st_nxt;
    logic lockRx;
    logic lockTx;
    logic lockSel;
    logic genBit;
    logic lfsrBit;
    logic checkRxIn;
    logic checkTxIn;
    logic access;
    logic csrHit;
    logic swHit;

    // ==============================================================
    // Checkers: one per path, each enabled only when it is the active one
    pattern_checker u_chk_rx (
        .clk      (clk),
        .rst      (rst),
        .enable   (st_r.ctrl.patternCheckEnable && !st_r.ctrl.patternSwitch),  // RULE4 RULE5
        .bitValid (bitValid),
        .qrts     (st_r.ctrl.patternTypeSelect),
        .dataIn   (checkRxIn),
        .locked   (lockRx)
    );

    pattern_checker u_chk_tx (
        .clk      (clk),
        .rst      (rst),
        .enable   (st_r.ctrl.patternCheckEnable && st_r.ctrl.patternSwitch),   // RULE4 RULE6
        .bitValid (bitValid),
        .qrts     (st_r.ctrl.patternTypeSelect),
        .dataIn   (checkTxIn),
        .locked   (lockTx)
    );

    // ==============================================================
    // Checker inputs, inverted when asked
    assign checkRxIn = streamIn.lineRxBit ^ st_r.ctrl.testDataInvert;   // RULE14
    assign checkTxIn = streamIn.backTxBit ^ st_r.ctrl.testDataInvert;   // RULE14
    assign lockSel   = st_r.ctrl.patternSwitch ? lockTx : lockRx;       // RULE3

    // ==============================================================
    // Bus decode
    assign access = wbCyc && wbStb && !st_r.ack;
    assign csrHit = wbAdr == pattern_test_pkg::CSR_ADDR;
    assign swHit  = wbAdr == pattern_test_pkg::SWITCH_ADDR;

    // ==============================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        // PRBS15 feedback; QRTS limits zero runs by forcing a one
        lfsrBit = st_r.lfsr[14] ^ st_r.lfsr[13];                        // RULE12
        genBit  = lfsrBit;
        if (st_r.ctrl.patternTypeSelect && st_r.zeros == pattern_test_pkg::QRTS_ZERO_MAX) begin
            genBit = 1'b1;                                              // RULE12
        end
        st_nxt.ack = access;
        if (access) begin
            st_nxt.datO = '0;
            if (csrHit) begin
                st_nxt.datO[7:0] = {st_r.ctrl.patternTypeSelect, st_r.ctrl.singleErrorInject,
                                    st_r.ctrl.testDataInvert, lockSel,   // RULE2
                                    st_r.ctrl.patternCheckEnable, st_r.ctrl.patternGenEnable,
                                    st_r.ctrl.rxFramerSkip, st_r.ctrl.txFramerSkip};
            end else if (swHit) begin
                st_nxt.datO[pattern_test_pkg::BIT_SWITCH] = st_r.ctrl.patternSwitch;
            end
            if (wbWe && wbSel[0]) begin
                if (csrHit) begin
                    st_nxt.ctrl.patternTypeSelect  = wbDatI[pattern_test_pkg::BIT_TYPE];
                    st_nxt.ctrl.singleErrorInject  = wbDatI[pattern_test_pkg::BIT_ERRINS];
                    st_nxt.ctrl.testDataInvert     = wbDatI[pattern_test_pkg::BIT_INVERT];
                    st_nxt.ctrl.patternCheckEnable = wbDatI[pattern_test_pkg::BIT_CHECK_EN]; // RULE4
                    st_nxt.ctrl.patternGenEnable   = wbDatI[pattern_test_pkg::BIT_GEN_EN];   // RULE7
                    st_nxt.ctrl.rxFramerSkip       = wbDatI[pattern_test_pkg::BIT_RX_SKIP];
                    st_nxt.ctrl.txFramerSkip       = wbDatI[pattern_test_pkg::BIT_TX_SKIP];
                    // A rising edge of the insert bit arms one error while generating
                    if (wbDatI[pattern_test_pkg::BIT_ERRINS] && !st_r.ctrl.singleErrorInject
                        && st_r.ctrl.patternGenEnable) begin
                        st_nxt.injectPend = 1'b1;                       // RULE13
                    end
                end else if (swHit) begin
                    st_nxt.ctrl.patternSwitch = wbDatI[pattern_test_pkg::BIT_SWITCH]; // RULE1
                end
            end
        end
        if (!st_r.ctrl.patternGenEnable) begin
            st_nxt.lfsr       = pattern_test_pkg::LFSR_SEED;
            st_nxt.zeros      = '0;
            st_nxt.injectPend = 1'b0;                                   // RULE13
        end
        // Default paths: framer data passes straight through
        st_nxt.out.lineTxBit = streamIn.framerTxBit;
        st_nxt.out.backRxBit = streamIn.framerRxBit;
        if (bitValid && st_r.ctrl.patternGenEnable) begin               // RULE7
            st_nxt.lfsr  = {st_r.lfsr[13:0], lfsrBit};
            st_nxt.zeros = genBit ? 5'h00 : st_r.zeros + 5'h01;
            if (st_r.ctrl.patternSwitch) begin
                st_nxt.out.backRxBit = genBit ^ st_r.ctrl.testDataInvert ^ st_r.injectPend; // RULE9 RULE14
            end else begin
                st_nxt.out.lineTxBit = genBit ^ st_r.ctrl.testDataInvert ^ st_r.injectPend; // RULE8 RULE14
            end
            // Set in this same cycle by a new write keeps the pending error alive
            if (!(st_nxt.injectPend && !st_r.injectPend)) begin
                st_nxt.injectPend = 1'b0;                               // RULE13
            end
        end else if (st_r.ctrl.patternGenEnable) begin
            // Hold the test stream between bit slots so the framer never sees bypassed data mid-test
            if (st_r.ctrl.patternSwitch) begin
                st_nxt.out.backRxBit = st_r.out.backRxBit;
            end else begin
                st_nxt.out.lineTxBit = st_r.out.lineTxBit;
            end
        end
        st_nxt.rxSkip = st_r.ctrl.rxFramerSkip;                         // RULE10
        st_nxt.txSkip = st_r.ctrl.txFramerSkip;                         // RULE11
    end

    // ==============================================================
    // State register; reset leaves every enable and bypass cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r      <= '0;                                            // RULE16
            st_r.lfsr <= pattern_test_pkg::LFSR_SEED;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==============================================================
    // Outputs straight from flip-flops
    assign wbDatO       = st_r.datO;
    assign wbAck        = st_r.ack;
    assign streamOut    = st_r.out;
    assign rxFramerSkip = st_r.rxSkip;
    assign txFramerSkip = st_r.txSkip;

    // ==============================================================
    // Checks
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst)
        wbAck |=> !wbAck) else $error("ack held longer than one cycle");

    a_switch_write: assert property (@(posedge clk) disable iff (rst)
        (access && wbWe && wbSel[0] && swHit) |=> (st_r.ctrl.patternSwitch == $past(wbDatI[3])))
        else $error("switch bit not written"); // RULE1

    a_lock_read: assert property (@(posedge clk) disable iff (rst)
        (access && !wbWe && csrHit) |=> (wbDatO[4] == $past(lockSel)))
        else $error("lock bit read wrong"); // RULE2

    a_lock_select: assert property (@(posedge clk) disable iff (rst)
        !st_r.ctrl.patternSwitch |-> (lockSel == lockRx)) else $error("lock source wrong"); // RULE3

    a_check_off: assert property (@(posedge clk) disable iff (rst)
        !st_r.ctrl.patternCheckEnable |=> !lockRx && !lockTx) else $error("lock without enable"); // RULE4

    a_gen_line: assert property (@(posedge clk) disable iff (rst)
        (bitValid && st_r.ctrl.patternGenEnable && !st_r.ctrl.patternSwitch)
        |=> (streamOut.lineTxBit == $past(genBit ^ st_r.ctrl.testDataInvert ^ st_r.injectPend)))
        else $error("line output not the pattern"); // RULE8

    a_gen_back: assert property (@(posedge clk) disable iff (rst)
        (bitValid && st_r.ctrl.patternGenEnable && st_r.ctrl.patternSwitch)
        |=> (streamOut.backRxBit == $past(genBit ^ st_r.ctrl.testDataInvert ^ st_r.injectPend)))
        else $error("backplane output not the pattern"); // RULE9

    a_gen_off_pass: assert property (@(posedge clk) disable iff (rst)
        !st_r.ctrl.patternGenEnable |=> (streamOut.lineTxBit == $past(streamIn.framerTxBit)))
        else $error("line output not passing framer data"); // RULE7

    a_rx_skip: assert property (@(posedge clk) disable iff (rst)
        st_r.ctrl.rxFramerSkip |=> rxFramerSkip) else $error("receive bypass not driven"); // RULE10

    a_tx_skip: assert property (@(posedge clk) disable iff (rst)
        !st_r.ctrl.txFramerSkip |=> !txFramerSkip) else $error("transmit bypass stuck"); // RULE11

    a_inject_once: assert property (@(posedge clk) disable iff (rst)
        (st_r.injectPend && bitValid && st_r.ctrl.patternGenEnable && !st_nxt.injectPend)
        |=> !st_r.injectPend) else $error("error inserted more than once"); // RULE13

endmodule : pattern_test_control

/* File: test/framer_model.sv */
// Framer-side model: bit slot strobes and line or backplane test data
`timescale 1ns/10ps
module framer_model (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    prbsLine,
    input  wire logic                    prbsBack,
    output logic                         bitValid,
    output pattern_test_pkg::stream_in_s streamIn
);
    logic [1:0]  slot_r;
    logic [14:0] lfsr_r;
    logic        fb;
    logic [3:0]  rnd;

    // PRBS15 feedback for x^15+x^14+1
    assign fb = lfsr_r[14] ^ lfsr_r[13];

    // ==========================================
    // Slot timing
    // One slot in four; data is random between slots so stale bits never look valid
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_r   <= 2'h0;
            lfsr_r   <= 15'h1234;
            bitValid <= 1'b0;
            streamIn <= '0;
        end else begin
            // One assignment of the stream per edge; pattern bits only in the slot
            rnd      = 4'($urandom);
            slot_r   <= slot_r + 2'h1;
            bitValid <= (slot_r == 2'h3);
            if (slot_r == 2'h3) begin
                lfsr_r   <= {lfsr_r[13:0], fb};
                streamIn <= {(prbsLine ? fb : rnd[3]), (prbsBack ? fb : rnd[2]), rnd[1:0]};
            end else begin
                streamIn <= rnd;
            end
        end
    end
endmodule : framer_model

/* File: test/test_t1_bit_error_test_control.sv */
// Testbench: registers, pass-through, generator, error flip and checker lock
`timescale 1ns/10ps
module test_t1_bit_error_test_control;
    localparam logic [7:0]  GEN = 8'h01 << pattern_test_pkg::BIT_GEN_EN;
    localparam logic [7:0]  CHK = 8'h01 << pattern_test_pkg::BIT_CHECK_EN;
    localparam logic [7:0]  INV = 8'h01 << pattern_test_pkg::BIT_INVERT;
    localparam logic [7:0]  ERR = 8'h01 << pattern_test_pkg::BIT_ERRINS;
    localparam logic [7:0]  LCK = 8'h01 << pattern_test_pkg::BIT_LOCK;
    localparam logic [7:0]  TYP = 8'h01 << pattern_test_pkg::BIT_TYPE;
    localparam logic [7:0]  SW  = 8'h01 << pattern_test_pkg::BIT_SWITCH;
    localparam logic [17:0] CSR = pattern_test_pkg::CSR_ADDR;
    localparam logic [17:0] SWR = pattern_test_pkg::SWITCH_ADDR;
    logic clk = 1'b0;
    logic rst;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, bitValid, rxFramerSkip, txFramerSkip;
    logic [17:0] wbAdr = 18'h0_0000;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0000_0000, wbDatO, rd;
    pattern_test_pkg::stream_in_s  streamIn;
    pattern_test_pkg::stream_out_s streamOut;
    logic prbsLine = 1'b0, prbsBack = 1'b0, ptLine = 1'b0, ptBack = 1'b0, useBack = 1'b0;
    logic prevTx = 1'b0, prevRx = 1'b0, vDly = 1'b0;
    logic q[$];
    int   fail_count = 0, checks_done = 0, ptErrs = 0;

    always #25 clk = ~clk;

    pattern_test_control pattern_test_control_inst (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .bitValid(bitValid), .streamIn(streamIn), .streamOut(streamOut), .rxFramerSkip(rxFramerSkip),
        .txFramerSkip(txFramerSkip));
    framer_model framer_model_inst (.clk(clk), .rst(rst), .prbsLine(prbsLine), .prbsBack(prbsBack),
        .bitValid(bitValid), .streamIn(streamIn));

    // ==========================================
    // Monitors
    // Pass-through paths are one cycle late; generated bits are taken a cycle after each slot
    always @(posedge clk) begin
        prevTx <= streamIn.framerTxBit;
        prevRx <= streamIn.framerRxBit;
        vDly   <= bitValid;
        if (ptLine && streamOut.lineTxBit !== prevTx) ptErrs++;
        if (ptBack && streamOut.backRxBit !== prevRx) ptErrs++;
        if (vDly) q.push_back(useBack ? streamOut.backRxBit : streamOut.lineTxBit);
    end

    // ==========================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Classic cycle; holds everything until ack is sampled high
    task automatic wb(input logic we, input logic [17:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= s;
        wbDatI <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 100);
        rd = wbDatO;
        if (n >= 100) check("bus answer", 32'h0000_0001, 32'h0000_0000);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        wb(1'b1, a, 4'h1, {24'h00_0000, d});
    endtask : wr

    task automatic rdr(input logic [17:0] a);
        wb(1'b0, a, 4'h1, 32'h0000_0000);
    endtask : rdr

    task automatic slots(input int n);
        repeat (n) @(posedge clk iff bitValid === 1'b1);
    endtask : slots

    // Drop bits from before a configuration change
    task automatic restart(input logic b);
        useBack = b;
        slots(2);
        q.delete();
    endtask : restart

    task automatic collect(input int n);
        int k;
        k = 0;
        while (q.size() < n && k < 5000) begin
            @(posedge clk);
            k++;
        end
    endtask : collect

    // Count breaks of the x^15+x^14+1 recurrence, inverted stream gives a constant 1
    function automatic int viol(input logic inv);
        int v;
        v = 0;
        for (int i = 15; i < q.size(); i++)
            if (q[i] !== (q[i-14] ^ q[i-15] ^ inv)) v++;
        return v;
    endfunction : viol

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        #2_000_000;
        fail_count++;
        stop_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        logic [7:0] v;
        rst = 1'b1;
        void'($urandom(32'h0000_fd10));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        ptLine <= 1'b1;
        ptBack <= 1'b1;
        rdr(CSR);
        check("csr reset", {24'h00_0000, pattern_test_pkg::CSR_RESET}, rd);
        rdr(SWR);
        check("switch reset", {24'h00_0000, pattern_test_pkg::SWITCH_RESET}, rd);
        check("rx skip reset", 32'h0000_0000, rxFramerSkip);
        check("tx skip reset", 32'h0000_0000, txFramerSkip);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? 8'(i) : 8'($urandom_range(3));
            wr(CSR, v);
            rdr(CSR);
            check("csr skip bits", {24'h00_0000, v}, rd);
            check("rx skip", v[1], rxFramerSkip);
            check("tx skip", v[0], txFramerSkip);
        end
        wr(CSR, LCK);
        rdr(CSR);
        check("lock read only", 32'h0000_0000, rd);
        wb(1'b1, CSR, 4'h0, 32'h0000_00ff);
        rdr(CSR);
        check("sel0 write ignored", 32'h0000_0000, rd);
        wr(18'h0_0100, 8'hff);
        rdr(18'h0_0100);
        check("unmapped read", 32'h0000_0000, rd);
        $display("test register access done");
        ptLine <= 1'b0;
        // Both pattern types: the forced one after fourteen zeros never breaks the recurrence
        for (int inv = 0; inv < 4; inv++) begin
            wr(CSR, GEN | (inv[0] ? INV : 8'h00) | (inv[1] ? TYP : 8'h00));
            restart(1'b0);
            collect(50);
            check("prbs line breaks", 32'h0000_0000, viol(inv[0]));
        end
        wr(CSR, GEN);
        restart(1'b0);
        collect(20);
        wr(CSR, GEN | ERR);
        collect(60);
        check("single flip breaks", 32'h0000_0003, viol(1'b0));
        $display("test line generator done");
        ptBack <= 1'b0;
        wr(SWR, SW);
        wr(CSR, GEN);
        restart(1'b1);
        ptLine <= 1'b1;
        collect(50);
        check("prbs backplane breaks", 32'h0000_0000, viol(1'b0));
        $display("test backplane generator done");
        wr(CSR, 8'h00);
        wr(SWR, 8'h00);
        slots(2);
        ptBack <= 1'b1;
        prbsLine <= 1'b1;
        wr(CSR, CHK);
        slots(100);
        rdr(CSR);
        check("lock line side", {24'h00_0000, CHK | LCK}, rd);
        wr(SWR, SW);
        slots(100);
        rdr(CSR);
        check("lock backplane idle", {24'h00_0000, CHK}, rd);
        prbsBack <= 1'b1;
        slots(100);
        rdr(CSR);
        check("lock backplane", {24'h00_0000, CHK | LCK}, rd);
        wr(CSR, 8'h00);
        rdr(CSR);
        check("lock cleared", 32'h0000_0000, rd);
        check("pass through errors", 32'h0000_0000, ptErrs);
        $display("test checker lock done");
        stop_test();
    end
endmodule : test_t1_bit_error_test_control
